// file: include/mic_pkg.sv
// constants, register map and field layout of the interrupt controller
package mic_pkg;
   // fetch vectors and program counter width
   localparam int PC_W = 11;
   localparam logic [10:0] VEC_TRAP = 11'h001;
   localparam logic [10:0] VEC_HW = 11'h008;

   // hardware event flag positions
   localparam int NUM_FLAGS = 11;
   localparam int FLG_TIMER0 = 0;
   localparam int FLG_TIMER1 = 1;
   localparam int FLG_TIMER2 = 2;
   localparam int FLG_TIMER3 = 3;
   localparam int FLG_PINCHG = 4;
   localparam int FLG_EXT0 = 5;
   localparam int FLG_WATCHDOG = 6;
   localparam int FLG_EXT1 = 7;
   localparam int FLG_LOWVOLT = 8;
   localparam int FLG_COMPARE = 9;
   localparam int FLG_ADC = 10;

   // timer wrap values
   localparam logic [7:0] T0_FROM = 8'h00;
   localparam logic [7:0] T0_TO = 8'hff;
   localparam logic [9:0] T10_FROM = 10'h3ff;
   localparam logic [9:0] T10_TO = 10'h000;

   // port widths
   localparam int PA_W = 8;
   localparam int PB_W = 6;
   localparam int SYNC_W = PA_W + PB_W + 2;

   // bus geometry and register byte offsets
   localparam int AXI_AW = 8;
   localparam logic [7:0] OFS_FLAG = 8'h00;
   localparam logic [7:0] OFS_ENABLE = 8'h04;
   localparam logic [7:0] OFS_WAKE = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0c;
   localparam logic [7:0] OFS_SYSSTAT = 8'h10;
   localparam logic [7:0] OFS_SYSMASK = 8'h14;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // register selector
   typedef enum logic [2:0] {
      MIC_SEL_FLAG = 3'b000,
      MIC_SEL_ENABLE = 3'b001,
      MIC_SEL_WAKE = 3'b010,
      MIC_SEL_CTRL = 3'b011,
      MIC_SEL_SYSSTAT = 3'b100,
      MIC_SEL_SYSMASK = 3'b101,
      MIC_SEL_NONE = 3'b111
   } mic_sel_t;

   // wake register field layout
   localparam int WAKE_PA_LSB = 0;
   localparam int WAKE_PB_LSB = 8;
   // control register field layout
   localparam int CTRL_EXT0_SEL = 0;
   localparam int CTRL_EXT1_SEL = 1;
   localparam int CTRL_EDGE_SEL = 2;
   localparam int CTRL_GIE = 8;
   localparam int CTRL_INSVC = 9;
   // system status layout
   localparam int NUM_SYS = 3;
   localparam int SYS_TRAP = 0;
   localparam int SYS_HWIRQ = 1;
   localparam int SYS_RETURN = 2;

   // reset values
   localparam logic [10:0] FLAG_RST = 11'h000;
   localparam logic [10:0] ENABLE_RST = 11'h000;
   localparam logic [13:0] WAKE_RST = 14'h0000;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [2:0] SYS_RST = 3'h0;
endpackage

// file: hw/mic_pin_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
module mic_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinOut
);
   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;

   // shift chain; stage1 feeds only stage2
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stage1_q <= '0;
         stage2_q <= '0;
         stage3_q <= '0;
      end else begin
         stage1_q <= pinIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   // a bit follows only when stages two and three agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_filt
         logic filtBit_q;
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               filtBit_q <= 1'b0;
            end else if (stage2_q[i] == stage3_q[i]) begin
               filtBit_q <= stage3_q[i];
            end
         end
         assign pinOut[i] = filtBit_q;
      end
   endgenerate
endmodule // mic_pin_sync

// file: hw/mic_irq_ctrl.sv
// interrupt controller: event flags, vectoring and AXI4-Lite registers
//
// Behaviour
// - trap vectors to 0x001 whatever the enable, clears global enable
// - hardware irqs need global enable; instructions set or clear it
// - return instruction sets global enable and resumes interrupted code
// - each event sets its flag; flag stays until firmware writes zero
// - a flag reads back only while its own enable bit is one
// - enabled flag under global enable vectors to 0x008, clears enable
// - timer 0 passing 0x00 to 0xFF sets timer 0 flag
// - timers 1 to 3 passing 0x3FF to 0x00 set their own flags
// - watchdog timeout sets its flag only when interrupt mode is chosen
// - level change on enabled wake input pins sets shared pin-change flag
// - external selects mask pin-change detection on port B bits 0 and 1
// - selected edge on port B bit 0 or 1 sets external flag
// - falling low-voltage detector output sets the low-voltage flag
// - comparator change sets flag; oscillator read clears stored difference
// - each converter end-of-conversion pulse sets the converter flag
// - watchdog flag and enable sit at bit 6 of their registers
module mic_irq_ctrl
   import mic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   // core sequencer
   input wire logic instrDone,
   input wire logic instrIsTrap,
   input wire logic instrIsEni,
   input wire logic instrIsDisi,
   input wire logic instrIsReti,
   input wire logic [PC_W-1:0] nextPc,
   output logic fetchRedirect,
   output logic [PC_W-1:0] fetchAddr,
   output logic stackPush,
   output logic [PC_W-1:0] pushAddr,
   output logic stackPop,
   output logic globalIrqEnable,
   output logic inService,
   output logic hwIrqPending,
   // peripheral events on the core clock
   input wire logic [7:0] timer0Count,
   input wire logic [9:0] timer1Count,
   input wire logic [9:0] timer2Count,
   input wire logic [9:0] timer3Count,
   input wire logic wdtTimeout,
   input wire logic wdtIrqMode,
   input wire logic [PA_W-1:0] portaIsInput,
   input wire logic [PB_W-1:0] portbIsInput,
   input wire logic oscCtrlRead,
   input wire logic adcEoc,
   // asynchronous pins
   input wire logic [PA_W-1:0] portaPin,
   input wire logic [PB_W-1:0] portbPin,
   input wire logic lvdOut,
   input wire logic cmpOut,
   // system interrupt
   output logic sysIrq,
   // AXI4-Lite slave
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // address decode shared by read and write
   function automatic mic_sel_t decodeSel(input logic [AXI_AW-1:0] a);
      case (a)
         OFS_FLAG: decodeSel = MIC_SEL_FLAG;
         OFS_ENABLE: decodeSel = MIC_SEL_ENABLE;
         OFS_WAKE: decodeSel = MIC_SEL_WAKE;
         OFS_CTRL: decodeSel = MIC_SEL_CTRL;
         OFS_SYSSTAT: decodeSel = MIC_SEL_SYSSTAT;
         OFS_SYSMASK: decodeSel = MIC_SEL_SYSMASK;
         default: decodeSel = MIC_SEL_NONE;
      endcase
   endfunction

   // merge write data into an old word under the byte strobes
   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
         input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      mergeStrb = (old & ~m) | (data & m);
   endfunction

   logic [NUM_FLAGS-1:0] flag_q;
   logic [NUM_FLAGS-1:0] enable_q;
   logic [PA_W+PB_W-1:0] wake_q;
   logic [2:0] ctrl_q;
   logic [NUM_SYS-1:0] sysStat_q;
   logic [NUM_SYS-1:0] sysMask_q;
   logic gie_q;
   logic inSvc_q;
   logic redirect_q;
   logic [PC_W-1:0] fetchAddr_q;
   logic push_q;
   logic [PC_W-1:0] pushAddr_q;
   logic pop_q;
   logic pending_q;
   logic sysIrq_q;
   logic [7:0] t0Prev_q;
   logic [9:0] t1Prev_q;
   logic [9:0] t2Prev_q;
   logic [9:0] t3Prev_q;
   logic [PA_W-1:0] paPrev_q;
   logic [PB_W-1:0] pbPrev_q;
   logic ext0Prev_q;
   logic ext1Prev_q;
   logic lvdPrev_q;
   logic cmpStored_q;
   logic cmpDiffPrev_q;
   logic [SYNC_W-1:0] syncOut;
   logic [PA_W-1:0] paSync;
   logic [PB_W-1:0] pbSync;
   logic lvdSync;
   logic cmpSync;
   logic [NUM_FLAGS-1:0] evt;
   logic [NUM_FLAGS-1:0] flagVisible;
   logic [NUM_FLAGS-1:0] wrClear;
   logic [NUM_SYS-1:0] sysEvt;
   logic hwReq;
   logic gieAfter;
   logic takeTrap;
   logic takeReti;
   logic takeHw;
   logic edgeSel;
   logic ext0Rise;
   logic ext1Rise;
   logic cmpDiff;
   // bus state
   logic awready_q;
   logic wready_q;
   logic awHeld_q;
   logic wHeld_q;
   logic [AXI_AW-1:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic doWrite;
   logic doRead;
   mic_sel_t wrSel;
   mic_sel_t rdSel;
   logic [31:0] wrWord;
   logic [31:0] rdWord;
   logic [31:0] oldWord;
   logic [NUM_SYS-1:0] sysStatD;

   // pins cross into the core clock
   mic_pin_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .pinIn({cmpOut, lvdOut, portbPin, portaPin}),
      .pinOut(syncOut)
   );
   assign paSync = syncOut[PA_W-1:0];
   assign pbSync = syncOut[PA_W+PB_W-1:PA_W];
   assign lvdSync = syncOut[PA_W+PB_W];
   assign cmpSync = syncOut[PA_W+PB_W+1];

   // previous samples for edge and wrap detection
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         t0Prev_q <= T0_FROM;
         t1Prev_q <= T10_TO;
         t2Prev_q <= T10_TO;
         t3Prev_q <= T10_TO;
         paPrev_q <= '0;
         pbPrev_q <= '0;
         ext0Prev_q <= 1'b0;
         ext1Prev_q <= 1'b0;
         lvdPrev_q <= 1'b0;
         cmpDiffPrev_q <= 1'b0;
      end else begin
         t0Prev_q <= timer0Count;
         t1Prev_q <= timer1Count;
         t2Prev_q <= timer2Count;
         t3Prev_q <= timer3Count;
         paPrev_q <= paSync;
         pbPrev_q <= pbSync;
         ext0Prev_q <= pbSync[0];
         ext1Prev_q <= pbSync[1];
         lvdPrev_q <= lvdSync;
         cmpDiffPrev_q <= cmpDiff;
      end
   end

   // comparator reference is refreshed by each oscillator register read
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmpStored_q <= 1'b0;
      end else if (oscCtrlRead) begin
         cmpStored_q <= cmpSync;
      end
   end
   assign cmpDiff = (cmpSync != cmpStored_q) & ~oscCtrlRead;

   // event detection
   always_comb begin
      logic [PB_W-1:0] pbMask;
      pbMask = wake_q[WAKE_PB_LSB +: PB_W] & portbIsInput;
      pbMask[0] = pbMask[0] & ~ctrl_q[CTRL_EXT0_SEL];
      pbMask[1] = pbMask[1] & ~ctrl_q[CTRL_EXT1_SEL];
      evt = '0;
      evt[FLG_TIMER0] = (t0Prev_q == T0_FROM)
            && (timer0Count == T0_TO);
      evt[FLG_TIMER1] = (t1Prev_q == T10_FROM)
            && (timer1Count == T10_TO);
      evt[FLG_TIMER2] = (t2Prev_q == T10_FROM)
            && (timer2Count == T10_TO);
      evt[FLG_TIMER3] = (t3Prev_q == T10_FROM)
            && (timer3Count == T10_TO);
      evt[FLG_WATCHDOG] = wdtTimeout & wdtIrqMode;
      evt[FLG_PINCHG] = |((paSync ^ paPrev_q) & wake_q[WAKE_PA_LSB +: PA_W]
            & portaIsInput) | |((pbSync ^ pbPrev_q) & pbMask);
      evt[FLG_EXT0] = ctrl_q[CTRL_EXT0_SEL] & ext0Rise;
      evt[FLG_EXT1] = ctrl_q[CTRL_EXT1_SEL] & ext1Rise;
      evt[FLG_LOWVOLT] = lvdPrev_q & ~lvdSync;
      evt[FLG_COMPARE] = cmpDiff & ~cmpDiffPrev_q;
      evt[FLG_ADC] = adcEoc;
   end

   // selected edge: select one means rising, zero means falling
   assign edgeSel = ctrl_q[CTRL_EDGE_SEL];
   assign ext0Rise = edgeSel ? (pbSync[0] & ~ext0Prev_q)
         : (~pbSync[0] & ext0Prev_q);
   assign ext1Rise = edgeSel ? (pbSync[1] & ~ext1Prev_q)
         : (~pbSync[1] & ext1Prev_q);

   // bus write strobe and the flags that a written zero clears
   assign doWrite = awHeld_q & wHeld_q & ~bvalid_q;
   assign doRead = s_axi_arvalid & arready_q;
   assign wrSel = decodeSel(awAddr_q);
   assign rdSel = decodeSel(s_axi_araddr);
   // old contents of the addressed register, for the byte-lane merge
   always_comb begin
      oldWord = '0;
      case (wrSel)
         MIC_SEL_FLAG: oldWord[NUM_FLAGS-1:0] = flag_q;
         MIC_SEL_ENABLE: oldWord[NUM_FLAGS-1:0] = enable_q;
         MIC_SEL_WAKE: oldWord[PA_W+PB_W-1:0] = wake_q;
         MIC_SEL_CTRL: oldWord[2:0] = ctrl_q;
         MIC_SEL_SYSMASK: oldWord[NUM_SYS-1:0] = sysMask_q;
         default: oldWord = '0;
      endcase
   end
   assign wrWord = mergeStrb(oldWord, wData_q, wStrb_q);
   assign wrClear = (doWrite && wrSel == MIC_SEL_FLAG)
         ? ~wrWord[NUM_FLAGS-1:0] : '0;

   // sticky event flags; a new event beats a written zero
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flag_q <= FLAG_RST;
      end else begin
         flag_q <= (flag_q & ~wrClear) | evt;
      end
   end

   // enable, wake and control registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         enable_q <= ENABLE_RST;
         wake_q <= WAKE_RST;
         ctrl_q <= CTRL_RST;
         sysMask_q <= SYS_RST;
      end else if (doWrite) begin
         case (wrSel)
            MIC_SEL_ENABLE: begin
               enable_q <= wrWord[NUM_FLAGS-1:0];
            end
            MIC_SEL_WAKE: begin
               wake_q <= wrWord[PA_W+PB_W-1:0];
            end
            MIC_SEL_CTRL: begin
               ctrl_q <= wrWord[2:0];
            end
            MIC_SEL_SYSMASK: begin
               sysMask_q <= wrWord[NUM_SYS-1:0];
            end
            default: begin
               enable_q <= enable_q;
            end
         endcase
      end
   end

   // vectoring decisions at the instruction boundary
   assign flagVisible = flag_q & enable_q;
   assign hwReq = |flagVisible;
   assign gieAfter = instrIsEni ? 1'b1 : (instrIsDisi ? 1'b0 : gie_q);
   assign takeTrap = instrDone & instrIsTrap;
   assign takeReti = instrDone & ~instrIsTrap & instrIsReti;
   assign takeHw = instrDone & ~instrIsTrap & ~instrIsReti & hwReq
         & gieAfter;

   // global enable and in-service state
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gie_q <= 1'b0;
         inSvc_q <= 1'b0;
      end else if (takeTrap) begin
         gie_q <= 1'b0;
         inSvc_q <= 1'b1;
      end else if (takeReti) begin
         gie_q <= 1'b1;
         inSvc_q <= 1'b0;
      end else if (takeHw) begin
         gie_q <= 1'b0;
         inSvc_q <= 1'b1;
      end else if (instrDone) begin
         gie_q <= gieAfter;
      end
   end

   // fetch redirect, return address push and pop toward the core
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         redirect_q <= 1'b0;
         fetchAddr_q <= '0;
         push_q <= 1'b0;
         pushAddr_q <= '0;
         pop_q <= 1'b0;
      end else begin
         redirect_q <= takeTrap | takeHw;
         push_q <= takeTrap | takeHw;
         pop_q <= takeReti;
         if (takeTrap) begin
            fetchAddr_q <= VEC_TRAP;
            pushAddr_q <= nextPc;
         end else if (takeHw) begin
            fetchAddr_q <= VEC_HW;
            pushAddr_q <= nextPc;
         end
      end
   end

   // pending indication and system interrupt status, cleared by read
   assign sysEvt = {takeReti, takeHw, takeTrap};
   // a read clears the status, but an event in that cycle still sets it
   assign sysStatD = (doRead && rdSel == MIC_SEL_SYSSTAT) ? sysEvt
         : (sysStat_q | sysEvt);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sysStat_q <= SYS_RST;
         sysIrq_q <= 1'b0;
         pending_q <= 1'b0;
      end else begin
         pending_q <= hwReq & gie_q;
         sysStat_q <= sysStatD;
         sysIrq_q <= |(sysStatD & sysMask_q);
      end
   end

   // write address and data channels, taken in either order
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= '0;
         wData_q <= '0;
         wStrb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid && wready_q) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
            wready_q <= 1'b0;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (wrSel == MIC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // read data multiplexer
   always_comb begin
      rdWord = '0;
      case (rdSel)
         MIC_SEL_FLAG: rdWord[NUM_FLAGS-1:0] = flagVisible;
         MIC_SEL_ENABLE: rdWord[NUM_FLAGS-1:0] = enable_q;
         MIC_SEL_WAKE: rdWord[PA_W+PB_W-1:0] = wake_q;
         MIC_SEL_CTRL: begin
            rdWord[2:0] = ctrl_q;
            rdWord[CTRL_GIE] = gie_q;
            rdWord[CTRL_INSVC] = inSvc_q;
         end
         MIC_SEL_SYSSTAT: rdWord[NUM_SYS-1:0] = sysStat_q;
         MIC_SEL_SYSMASK: rdWord[NUM_SYS-1:0] = sysMask_q;
         default: rdWord = '0;
      endcase
   end

   // read channel: one read in flight, answer one cycle after address
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else begin
         if (doRead) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rdWord;
            rresp_q <= (rdSel == MIC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // outputs straight from flip-flops
   assign fetchRedirect = redirect_q;
   assign fetchAddr = fetchAddr_q;
   assign stackPush = push_q;
   assign pushAddr = pushAddr_q;
   assign stackPop = pop_q;
   assign globalIrqEnable = gie_q;
   assign inService = inSvc_q;
   assign hwIrqPending = pending_q;
   assign sysIrq = sysIrq_q;
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rvalid = rvalid_q;
endmodule // mic_irq_ctrl

// file: bench/mic_irq_chk.sv
// concurrent checks on the core-facing ports of the controller
module mic_irq_chk
   import mic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic instrDone,
   input wire logic instrIsTrap,
   input wire logic instrIsEni,
   input wire logic instrIsDisi,
   input wire logic instrIsReti,
   input wire logic [PC_W-1:0] nextPc,
   input wire logic fetchRedirect,
   input wire logic [PC_W-1:0] fetchAddr,
   input wire logic stackPush,
   input wire logic [PC_W-1:0] pushAddr,
   input wire logic stackPop,
   input wire logic globalIrqEnable,
   input wire logic inService
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // boundary with trap and redirect to a vector
   sequence s_trap;
      instrDone && instrIsTrap;
   endsequence
   sequence s_vec(v);
      fetchRedirect && fetchAddr == v;
   endsequence
   property p_trap;
      s_trap |=> s_vec(VEC_TRAP) ##0 !globalIrqEnable && inService;
   endproperty
   property p_hw;
      s_vec(VEC_HW) |-> !globalIrqEnable && inService && stackPush;
   endproperty
   property p_gate;
      instrDone && !instrIsEni && !globalIrqEnable |=> not s_vec(VEC_HW);
   endproperty
   property p_disable_irq_instr;
      instrDone && instrIsDisi && !instrIsReti |=> !globalIrqEnable;
   endproperty
   property p_eni;
      instrDone && instrIsEni && !instrIsTrap && !instrIsReti
         |=> s_vec(VEC_HW) or globalIrqEnable;
   endproperty
   property p_reti;
      instrDone && instrIsReti && !instrIsTrap
         |=> stackPop && globalIrqEnable && !inService;
   endproperty
   property p_push;
      fetchRedirect |-> stackPush && pushAddr == $past(nextPc);
   endproperty
   property p_bound;
      fetchRedirect || stackPop |-> $past(instrDone);
   endproperty
   a_trap: assert property (p_trap)
      else $error("trap vector wrong");
   a_hw: assert property (p_hw)
      else $error("hw vector state wrong");
   a_gate: assert property (p_gate)
      else $error("hw taken while disabled");
   a_disable_irq_instr: assert property (p_disable_irq_instr)
      else $error("disable left enable set");
   a_eni: assert property (p_eni)
      else $error("enable not set");
   a_reti: assert property (p_reti)
      else $error("return state wrong");
   a_push: assert property (p_push)
      else $error("return address wrong");
   a_bound: assert property (p_bound)
      else $error("action off boundary");
endmodule // mic_irq_chk

// file: bench/mic_core_model.sv
// instruction sequencer model driving boundaries toward the controller
module mic_core_model
   import mic_pkg::*;
(
   input wire logic clk_sys,
   output logic instrDone,
   output logic instrIsTrap,
   output logic instrIsEni,
   output logic instrIsDisi,
   output logic instrIsReti,
   output logic [PC_W-1:0] nextPc
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle at time zero
   initial begin
      {instrDone, instrIsTrap, instrIsEni, instrIsDisi, instrIsReti} = '0;
      nextPc = '0;
   end
   // one instruction, k = trap eni disable_irq_instr reti; boundary lasts one cycle
   task automatic exec(input logic [3:0] k, input logic [PC_W-1:0] pc);
      @(posedge clk_sys);
      instrDone <= 1'b1;
      {instrIsTrap, instrIsEni, instrIsDisi, instrIsReti} <= k;
      nextPc <= pc;
      @(posedge clk_sys);
      instrDone <= 1'b0;
      {instrIsTrap, instrIsEni, instrIsDisi, instrIsReti} <= 4'h0;
   endtask
endmodule // mic_core_model

// file: bench/tb.sv
// self-checking bench for the interrupt controller
module tb
   import mic_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 0;
   logic rst = 1;
   logic instrDone, instrIsTrap, instrIsEni, instrIsDisi, instrIsReti;
   logic [PC_W-1:0] nextPc, fetchAddr, pushAddr;
   logic fetchRedirect, stackPush, stackPop, globalIrqEnable, inService;
   logic hwIrqPending, sysIrq, wdtTimeout, wdtIrqMode, oscCtrlRead;
   logic adcEoc, lvdOut, cmpOut;
   logic [7:0] timer0Count, s_axi_awaddr, s_axi_araddr;
   logic [9:0] timer1Count, timer2Count, timer3Count;
   logic [PA_W-1:0] portaIsInput, portaPin;
   logic [PB_W-1:0] portbIsInput, portbPin;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int n_fail = 0;
   int cmp_count = 0;

   mic_irq_ctrl i_mic_irq_ctrl (.*);
   mic_core_model i_mic_core_model (.*);

   // 40 MHz clock
   always #12.5 clk_sys = ~clk_sys;

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic report_and_stop();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // bus write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      chk(s_axi_bresp, er);
   endtask

   // bus read with data and response compare
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
         input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, er);
   endtask

   // let an event settle, check the flags, then clear them all
   task automatic evt(input logic [31:0] e);
      repeat (8) @(posedge clk_sys);
      rd(OFS_FLAG, e, RESP_OKAY);
      wr(OFS_FLAG, 0, RESP_OKAY);
   endtask

   // one instruction; e = redirect, global enable, pop
   task automatic co(input logic [3:0] k, input logic [10:0] pc,
         input logic [2:0] e, input logic [10:0] v);
      i_mic_core_model.exec(k, pc);
      #1;
      chk({fetchRedirect, globalIrqEnable, stackPop}, e);
      if (e[2]) chk(fetchAddr, v);
   endtask

   // watchdog against a hang
   initial begin
      repeat (6000) @(posedge clk_sys);
      n_fail++;
      report_and_stop();
   end

   // main sequence
   initial begin
      {wdtTimeout, wdtIrqMode, oscCtrlRead, adcEoc, cmpOut} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, portaPin, portbPin, timer0Count} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      lvdOut = 1;
      {timer1Count, timer2Count, timer3Count} = '1;
      portaIsInput = '1;
      portbIsInput = '1;
      repeat (5) @(posedge clk_sys);
      rst <= 0;
      rd(OFS_ENABLE, 0, RESP_OKAY);
      rd(OFS_CTRL, 0, RESP_OKAY);
      rd(8'h18, 0, RESP_SLVERR);
      wr(8'h1c, 1, RESP_SLVERR);
      adcEoc <= 1;
      @(posedge clk_sys);
      adcEoc <= 0;
      rd(OFS_FLAG, 0, RESP_OKAY);
      wr(OFS_ENABLE, 32'h7ff, RESP_OKAY);
      rd(OFS_FLAG, 32'h400, RESP_OKAY);
      wr(OFS_FLAG, 32'h7ff, RESP_OKAY);
      evt(32'h400);
      evt(0);
      timer0Count <= 8'hff;
      {timer1Count, timer2Count, timer3Count} <= '0;
      evt(32'h00f);
      timer0Count <= 8'h00;
      evt(0);
      for (int m = 0; m < 2; m++) begin
         wdtIrqMode <= m[0];
         wdtTimeout <= 1;
         @(posedge clk_sys);
         wdtTimeout <= 0;
         evt(m ? 32'h040 : 0);
      end
      lvdOut <= 0;
      evt(32'h100);
      lvdOut <= 1;
      evt(0);
      oscCtrlRead <= 1;
      @(posedge clk_sys);
      oscCtrlRead <= 0;
      cmpOut <= 1;
      evt(32'h200);
      wr(OFS_WAKE, 32'h108, RESP_OKAY);
      portaPin[3] <= 1;
      evt(32'h010);
      wr(OFS_CTRL, 32'h5, RESP_OKAY);
      portbPin[0] <= 1;
      evt(32'h020);
      wr(OFS_WAKE, 32'h008, RESP_OKAY);
      wr(OFS_CTRL, 32'h2, RESP_OKAY);
      portbPin[1] <= 1;
      evt(0);
      portbPin[1] <= 0;
      evt(32'h080);
      // instruction flow, status and the system interrupt line
      wr(OFS_SYSMASK, 1, RESP_OKAY);
      co(4'h8, 11'h123, 3'b100, VEC_TRAP);
      chk(pushAddr, 11'h123);
      repeat (3) @(posedge clk_sys);
      #1 chk(sysIrq, 1);
      rd(OFS_SYSSTAT, 1, RESP_OKAY);
      repeat (3) @(posedge clk_sys);
      #1 chk(sysIrq, 0);
      co(4'h1, 11'h0, 3'b011, 0);
      co(4'h2, 11'h0, 3'b000, 0);
      adcEoc <= 1;
      @(posedge clk_sys);
      adcEoc <= 0;
      co(4'h0, 11'h0, 3'b000, 0);
      co(4'h4, 11'h055, 3'b100, VEC_HW);
      chk(pushAddr, 11'h055);
      co(4'h4, 11'h066, 3'b100, VEC_HW);
      wr(OFS_FLAG, 0, RESP_OKAY);
      co(4'h0, 11'h0, 3'b000, 0);
      co(4'h1, 11'h0, 3'b011, 0);
      co(4'h0, 11'h0, 3'b010, 0);
      #1 chk(hwIrqPending, 0);
      @(posedge clk_sys);
      adcEoc <= 1;
      @(posedge clk_sys);
      adcEoc <= 0;
      repeat (2) @(posedge clk_sys);
      #1 chk(hwIrqPending, 1);
      rd(OFS_SYSSTAT, 32'h6, RESP_OKAY);
      chk(sysIrq, 0);
      report_and_stop();
   end
endmodule // tb

bind mic_irq_ctrl mic_irq_chk i_mic_irq_chk (.*);
